// File: verilog/cpurf_top.v
// cpu register set: data, address, base, pc, stack and flag registers
// Operation
// - four 16-bit data words, all four byte-splittable
// - third/first and fourth/second pair as 32-bit
// - two 16-bit address words, pairable to 32
// - 16-bit frame base for relative addressing
// - 20-bit vector table base register
// - 20-bit program counter, next instruction address
// - user/interrupt stack pointers, stack flag selects
// - 16-bit static base for relative addressing
// - 11-bit processor state word
// - carry flag takes alu carry/borrow/shift-out
// - zero flag set on zero result
// - sign flag set on negative result
// - bank flag picks register bank 0/1
// - overflow flag set on overflow
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "cpurf_map.vh"
module cpurf_top #(
	parameter DW = 16,
	parameter AW = 20,
	parameter FW = 11
) (
	input  wire          I_CORE_CLK,
	input  wire          I_SYS_RST,
	input  wire [3:0]    I_WR_IDX,
	input  wire [DW-1:0] I_WR_DATA,
	input  wire          I_WR_HI,
	input  wire          I_WR_LO,
	input  wire [1:0]    I_LWR_IDX,
	input  wire [31:0]   I_LWR_DATA,
	input  wire          I_LWR_EN,
	input  wire [3:0]    I_RD_IDX,
	input  wire          I_RD_EN,
	input  wire [1:0]    I_LRD_IDX,
	input  wire          I_LRD_EN,
	input  wire          I_PC_LOAD,
	input  wire [AW-1:0] I_PC_DATA,
	input  wire          I_PC_INC,
	input  wire [2:0]    I_PC_STEP,
	input  wire          I_VTB_LOAD,
	input  wire [AW-1:0] I_VTB_DATA,
	input  wire          I_ALU_UPD,
	input  wire [DW-1:0] I_ALU_RESULT,
	input  wire          I_ALU_BYTE,
	input  wire          I_ALU_CARRY,
	input  wire          I_ALU_OVF,
	input  wire          I_UPD_C,
	input  wire          I_UPD_ZS,
	input  wire          I_UPD_O,
	output reg  [DW-1:0] O_RD_DATA,
	output reg  [31:0]   O_LRD_DATA,
	output reg  [AW-1:0] O_PC,
	output reg  [AW-1:0] O_VTB,
	output reg  [DW-1:0] O_SP,
	output reg  [DW-1:0] O_FB,
	output reg  [DW-1:0] O_SB,
	output reg  [FW-1:0] O_FLG,
	output reg           O_BANK
);
	// two banks of data and address words, plus fb
	wire [DW-1:0] bank_q [0:13];
	reg  [13:0]   we_hi;
	reg  [13:0]   we_lo;
	reg  [DW-1:0] wd [0:13];
	wire [DW-1:0] sb_q;
	wire [DW-1:0] usp_q;
	wire [DW-1:0] isp_q;
	wire          sb_sel;
	wire          usp_sel;
	wire          isp_sel;
	reg  [AW-1:0] pc_q;
	reg  [AW-1:0] vtb_q;
	reg  [FW-1:0] flg_q;
	reg  [FW-1:0] flg_d;
	reg  [DW-1:0] rd_d;
	reg  [31:0]   lrd_d;
	wire          bank;
	wire [3:0]    boff;
	wire [DW-1:0] sp_act;
	wire          res_zero;
	wire          res_neg;
	integer       k;

	assign bank = flg_q[`CPURF_FLG_B];
	// wide enough for bank 1 slots up to index 13
	assign boff = bank ? 4'h7 : 4'h0;
	assign sp_act = flg_q[`CPURF_FLG_U] ? usp_q : isp_q;
	assign res_zero = I_ALU_BYTE ? (I_ALU_RESULT[7:0] == 8'h00) : (I_ALU_RESULT == 16'h0000);
	assign res_neg = I_ALU_BYTE ? I_ALU_RESULT[7] : I_ALU_RESULT[DW-1];

	genvar g;
	generate
		for (g = 0; g < 14; g = g + 1) begin : g_word
			cpurf_word_reg #(
				.W(DW)
			) u_word (
				.i_clk   (I_CORE_CLK),
				.i_rst   (I_SYS_RST),
				.i_we_hi (we_hi[g]),
				.i_we_lo (we_lo[g]),
				.i_d     (wd[g]),
				.o_q     (bank_q[g])
			);
		end
	endgenerate

	assign sb_sel = (I_WR_IDX == `CPURF_IDX_SB);
	cpurf_word_reg #(
		.W(DW)
	) u_sb (
		.i_clk   (I_CORE_CLK),
		.i_rst   (I_SYS_RST),
		.i_we_hi (sb_sel & I_WR_HI),
		.i_we_lo (sb_sel & I_WR_LO),
		.i_d     (I_WR_DATA),
		.o_q     (sb_q)
	);

	// active pointer writes follow stack flag
	assign usp_sel = (I_WR_IDX == `CPURF_IDX_USP) || (I_WR_IDX == `CPURF_IDX_SP && flg_q[`CPURF_FLG_U]);
	assign isp_sel = (I_WR_IDX == `CPURF_IDX_ISP) || (I_WR_IDX == `CPURF_IDX_SP && !flg_q[`CPURF_FLG_U]);
	cpurf_word_reg #(
		.W(DW)
	) u_usp (
		.i_clk   (I_CORE_CLK),
		.i_rst   (I_SYS_RST),
		.i_we_hi (usp_sel & I_WR_HI),
		.i_we_lo (usp_sel & I_WR_LO),
		.i_d     (I_WR_DATA),
		.o_q     (usp_q)
	);
	cpurf_word_reg #(
		.W(DW)
	) u_isp (
		.i_clk   (I_CORE_CLK),
		.i_rst   (I_SYS_RST),
		.i_we_hi (isp_sel & I_WR_HI),
		.i_we_lo (isp_sel & I_WR_LO),
		.i_d     (I_WR_DATA),
		.o_q     (isp_q)
	);

	// write decode for banked words
	always @* begin
		for (k = 0; k < 14; k = k + 1) begin
			we_hi[k] = 1'b0;
			we_lo[k] = 1'b0;
			wd[k] = I_WR_DATA;
		end
		if (I_WR_IDX <= `CPURF_IDX_FB) begin
			we_hi[boff + I_WR_IDX[2:0]] = I_WR_HI;
			we_lo[boff + I_WR_IDX[2:0]] = I_WR_LO;
		end
		if (I_LWR_EN && I_LWR_IDX == `CPURF_LIDX_DL_A) begin
			we_hi[boff] = 1'b1;
			we_lo[boff] = 1'b1;
			wd[boff] = I_LWR_DATA[15:0];
			we_hi[boff + 3'd2] = 1'b1;
			we_lo[boff + 3'd2] = 1'b1;
			wd[boff + 3'd2] = I_LWR_DATA[31:16];
		end
		if (I_LWR_EN && I_LWR_IDX == `CPURF_LIDX_DL_B) begin
			we_hi[boff + 3'd1] = 1'b1;
			we_lo[boff + 3'd1] = 1'b1;
			wd[boff + 3'd1] = I_LWR_DATA[15:0];
			we_hi[boff + 3'd3] = 1'b1;
			we_lo[boff + 3'd3] = 1'b1;
			wd[boff + 3'd3] = I_LWR_DATA[31:16];
		end
		if (I_LWR_EN && I_LWR_IDX == `CPURF_LIDX_AL) begin
			we_hi[boff + 3'd4] = 1'b1;
			we_lo[boff + 3'd4] = 1'b1;
			wd[boff + 3'd4] = I_LWR_DATA[15:0];
			we_hi[boff + 3'd5] = 1'b1;
			we_lo[boff + 3'd5] = 1'b1;
			wd[boff + 3'd5] = I_LWR_DATA[31:16];
		end
	end

	// flag update from alu and direct writes
	always @* begin
		flg_d = flg_q;
		if (I_WR_IDX == `CPURF_IDX_FLG) begin
			if (I_WR_LO) begin
				flg_d[7:0] = I_WR_DATA[7:0];
			end
			if (I_WR_HI) begin
				flg_d[FW-1:8] = I_WR_DATA[FW-1:8];
			end
		end
		if (I_ALU_UPD) begin
			if (I_UPD_C) begin
				flg_d[`CPURF_FLG_C] = I_ALU_CARRY;
			end
			if (I_UPD_ZS) begin
				flg_d[`CPURF_FLG_Z] = res_zero;
				flg_d[`CPURF_FLG_S] = res_neg;
			end
			if (I_UPD_O) begin
				flg_d[`CPURF_FLG_O] = I_ALU_OVF;
			end
		end
	end

	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			flg_q <= `CPURF_FLG_RST;
			pc_q <= `CPURF_ADDR_RST;
			vtb_q <= `CPURF_ADDR_RST;
		end else begin
			flg_q <= flg_d;
			if (I_VTB_LOAD) begin
				vtb_q <= I_VTB_DATA;
			end else if (I_WR_IDX == `CPURF_IDX_VTB_LO && I_WR_HI && I_WR_LO) begin
				vtb_q[15:0] <= I_WR_DATA;
			end else if (I_WR_IDX == `CPURF_IDX_VTB_HI && I_WR_LO) begin
				vtb_q[AW-1:16] <= I_WR_DATA[3:0];
			end
			if (I_PC_LOAD) begin
				pc_q <= I_PC_DATA;
			end else if (I_PC_INC) begin
				pc_q <= pc_q + {17'h00000, I_PC_STEP};
			end
		end
	end

	// read mux
	always @* begin
		rd_d = O_RD_DATA;
		if (I_RD_EN) begin
			case (I_RD_IDX)
				`CPURF_IDX_SB:     rd_d = sb_q;
				`CPURF_IDX_USP:    rd_d = usp_q;
				`CPURF_IDX_ISP:    rd_d = isp_q;
				`CPURF_IDX_SP:     rd_d = sp_act;
				`CPURF_IDX_FLG:    rd_d = {5'h00, flg_q};
				`CPURF_IDX_VTB_LO: rd_d = vtb_q[15:0];
				`CPURF_IDX_VTB_HI: rd_d = {12'h000, vtb_q[AW-1:16]};
				`CPURF_IDX_PC_LO:  rd_d = pc_q[15:0];
				`CPURF_IDX_PC_HI:  rd_d = {12'h000, pc_q[AW-1:16]};
				default:           rd_d = bank_q[boff + I_RD_IDX[2:0]];
			endcase
		end
		lrd_d = O_LRD_DATA;
		if (I_LRD_EN) begin
			case (I_LRD_IDX)
				`CPURF_LIDX_DL_A: lrd_d = {bank_q[boff + 3'd2], bank_q[boff]};
				`CPURF_LIDX_DL_B: lrd_d = {bank_q[boff + 3'd3], bank_q[boff + 3'd1]};
				`CPURF_LIDX_AL:   lrd_d = {bank_q[boff + 3'd5], bank_q[boff + 3'd4]};
				default:          lrd_d = 32'h00000000;
			endcase
		end
	end

	// registered outputs
	always @(posedge I_CORE_CLK) begin
		if (I_SYS_RST) begin
			O_RD_DATA <= `CPURF_WORD_RST;
			O_LRD_DATA <= 32'h00000000;
			O_PC <= `CPURF_ADDR_RST;
			O_VTB <= `CPURF_ADDR_RST;
			O_SP <= `CPURF_WORD_RST;
			O_FB <= `CPURF_WORD_RST;
			O_SB <= `CPURF_WORD_RST;
			O_FLG <= `CPURF_FLG_RST;
			O_BANK <= 1'b0;
		end else begin
			O_RD_DATA <= rd_d;
			O_LRD_DATA <= lrd_d;
			O_PC <= pc_q;
			O_VTB <= vtb_q;
			O_SP <= sp_act;
			O_FB <= bank_q[boff + 3'd6];
			O_SB <= sb_q;
			O_FLG <= flg_q;
			O_BANK <= bank;
		end
	end
endmodule

// File: shared/cpurf_map.vh
// constants of the cpu register set
`ifndef CPURF_MAP_VH
`define CPURF_MAP_VH
`define CPURF_IDX_DW0 4'h0
`define CPURF_IDX_DW1 4'h1
`define CPURF_IDX_DW2 4'h2
`define CPURF_IDX_DW3 4'h3
`define CPURF_IDX_AW0 4'h4
`define CPURF_IDX_AW1 4'h5
`define CPURF_IDX_FB 4'h6
`define CPURF_IDX_SB 4'h7
`define CPURF_IDX_USP 4'h8
`define CPURF_IDX_ISP 4'h9
`define CPURF_IDX_SP 4'ha
`define CPURF_IDX_FLG 4'hb
`define CPURF_IDX_VTB_LO 4'hc
`define CPURF_IDX_VTB_HI 4'hd
`define CPURF_IDX_PC_LO 4'he
`define CPURF_IDX_PC_HI 4'hf
`define CPURF_LIDX_DL_A 2'h0
`define CPURF_LIDX_DL_B 2'h1
`define CPURF_LIDX_AL 2'h2
`define CPURF_FLG_C 0
`define CPURF_FLG_D 1
`define CPURF_FLG_Z 2
`define CPURF_FLG_S 3
`define CPURF_FLG_B 4
`define CPURF_FLG_O 5
`define CPURF_FLG_U 7
`define CPURF_FLG_RST 11'h000
`define CPURF_WORD_RST 16'h0000
`define CPURF_ADDR_RST 20'h00000
`define CPURF_HI_NIB 4'h0
`endif

// File: verilog/cpurf_word_reg.v
// one 16-bit register with separate byte-lane writes
`timescale 1ns/1ps
module cpurf_word_reg #(
	parameter W = 16
) (
	input  wire         i_clk,
	input  wire         i_rst,
	input  wire         i_we_hi,
	input  wire         i_we_lo,
	input  wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);
	reg [W-1:0] word_q;
	assign o_q = word_q;
	always @(posedge i_clk) begin
		if (i_rst) begin
			word_q <= {W{1'b0}};
		end else begin
			if (i_we_hi) begin
				word_q[W-1:W/2] <= i_d[W-1:W/2];
			end
			if (i_we_lo) begin
				word_q[W/2-1:0] <= i_d[W/2-1:0];
			end
		end
	end
endmodule

// File: dv/cpurf_properties.sv
// port assertions for the cpu register set
`timescale 1ns/1ps
module cpurf_properties (
	input wire        I_CORE_CLK,
	input wire        I_SYS_RST,
	input wire        I_PC_LOAD,
	input wire [19:0] I_PC_DATA,
	input wire        I_PC_INC,
	input wire [2:0]  I_PC_STEP,
	input wire        I_VTB_LOAD,
	input wire [19:0] I_VTB_DATA,
	input wire        I_ALU_UPD,
	input wire [15:0] I_ALU_RESULT,
	input wire        I_ALU_BYTE,
	input wire        I_ALU_CARRY,
	input wire        I_ALU_OVF,
	input wire        I_UPD_C,
	input wire        I_UPD_ZS,
	input wire        I_UPD_O,
	input wire [19:0] O_PC,
	input wire [19:0] O_VTB,
	input wire [10:0] O_FLG,
	input wire        O_BANK
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_SYS_RST);
	wire cu = I_ALU_UPD && I_UPD_C;
	wire zs = I_ALU_UPD && I_UPD_ZS;
	wire ou = I_ALU_UPD && I_UPD_O;
	wire inc = I_PC_INC && !I_PC_LOAD;
	wire z = I_ALU_BYTE ? ~|I_ALU_RESULT[7:0] : ~|I_ALU_RESULT;
	wire s = I_ALU_BYTE ? I_ALU_RESULT[7] : I_ALU_RESULT[15];
	carry_flag_a: assert property (cu |=> ##1 O_FLG[0] == $past(I_ALU_CARRY, 2)) else $error("carry");
	zero_flag_a: assert property (zs |=> ##1 O_FLG[2] == $past(z, 2)) else $error("zero");
	sign_flag_a: assert property (zs |=> ##1 O_FLG[3] == $past(s, 2)) else $error("sign");
	ovf_flag_a: assert property (ou |=> ##1 O_FLG[5] == $past(I_ALU_OVF, 2)) else $error("overflow");
	pc_load_a: assert property (I_PC_LOAD |=> ##1 O_PC == $past(I_PC_DATA, 2)) else $error("pc load");
	pc_step_a: assert property (inc |=> ##1 O_PC == $past(O_PC) + $past(I_PC_STEP, 2)) else $error("pc step");
	vtb_load_a: assert property (I_VTB_LOAD |=> ##1 O_VTB == $past(I_VTB_DATA, 2)) else $error("vtb");
	bank_out_a: assert property (O_BANK == O_FLG[4]) else $error("bank");
	cover property (zs && I_ALU_BYTE);
	cover property (inc);
	cover property (I_VTB_LOAD);
endmodule
bind cpurf_top cpurf_properties i_props (.*);

// File: dv/cpurf_alu_model.sv
// alu side model: one add and flag update per request
`timescale 1ns/1ps
module cpurf_alu_model (
	input  wire        i_clk,
	input  wire        i_go,
	input  wire [15:0] i_a,
	input  wire [15:0] i_b,
	input  wire        i_byte,
	output reg         o_upd,
	output reg  [15:0] o_res,
	output reg         o_c,
	output reg         o_o
);
	wire [16:0] r = i_byte ? i_a[7:0] + i_b[7:0] : i_a + i_b;
	always @(posedge i_clk) begin
		o_upd <= i_go;
		o_res <= i_go ? r[15:0] : ~o_res;
		o_c <= i_byte ? r[8] : r[16];
		o_o <= i_byte ? i_a[7] == i_b[7] && r[7] != i_a[7] : i_a[15] == i_b[15] && r[15] != i_a[15];
	end
endmodule

// File: dv/cpurf_top_tb.sv
// self-checking bench for the cpu register set
`timescale 1ns/1ps
module cpurf_top_tb;
	reg I_CORE_CLK, I_SYS_RST, I_WR_HI, I_WR_LO, I_LWR_EN, I_RD_EN, I_LRD_EN, I_PC_LOAD, I_PC_INC;
	reg I_VTB_LOAD, I_ALU_BYTE, I_UPD_C, I_UPD_ZS, I_UPD_O, go;
	reg [3:0] I_WR_IDX, I_RD_IDX, f;
	reg [1:0] I_LWR_IDX, I_LRD_IDX;
	reg [2:0] I_PC_STEP;
	reg [15:0] I_WR_DATA, a, b, ex [0:9];
	reg [31:0] I_LWR_DATA, d;
	reg [19:0] I_PC_DATA, I_VTB_DATA;
	reg [10:0] fx;
	integer i, n, failures, total_checks;
	wire I_ALU_UPD, I_ALU_CARRY, I_ALU_OVF, O_BANK;
	wire [15:0] I_ALU_RESULT, O_RD_DATA, O_SP, O_FB, O_SB;
	wire [31:0] O_LRD_DATA;
	wire [19:0] O_PC, O_VTB;
	wire [10:0] O_FLG;
	cpurf_alu_model i_alu (.i_clk(I_CORE_CLK), .i_go(go), .i_a(a), .i_b(b), .i_byte(I_ALU_BYTE),
		.o_upd(I_ALU_UPD), .o_res(I_ALU_RESULT), .o_c(I_ALU_CARRY), .o_o(I_ALU_OVF));
	cpurf_top i_dut (.*);
	task chk(input [31:0] s, input [31:0] e);
		begin
			total_checks = total_checks + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task wr(input [3:0] x, input [17:0] v);
		begin
			@(posedge I_CORE_CLK);
			{I_WR_IDX, I_WR_HI, I_WR_LO, I_WR_DATA} <= {x, v};
			@(posedge I_CORE_CLK);
			{I_WR_HI, I_WR_LO} <= 2'b00;
		end
	endtask
	task rd(input [3:0] x, input [15:0] e);
		begin
			@(posedge I_CORE_CLK);
			{I_RD_IDX, I_RD_EN} <= {x, 1'b1};
			@(posedge I_CORE_CLK);
			I_RD_EN <= 1'b0;
			#1 chk(O_RD_DATA, e);
		end
	endtask
	function [3:0] flags(input [15:0] x, input [15:0] y, input bm);
		integer m, s, sx;
		begin
			m = bm ? 256 : 65536;
			s = x % m + y % m;
			sx = x % m >= m / 2;
			flags = {sx == (y % m >= m / 2) && (s % m >= m / 2) != sx, s % m >= m / 2, s % m == 0, s >= m};
		end
	endfunction
	task finish_test;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		I_CORE_CLK = 1'b0;
		forever #5 I_CORE_CLK = ~I_CORE_CLK;
	end
	initial begin
		{I_WR_HI, I_WR_LO, I_LWR_EN, I_RD_EN, I_LRD_EN, I_PC_LOAD, I_PC_INC, I_VTB_LOAD, go} = 0;
		{I_WR_IDX, I_RD_IDX, I_LWR_IDX, I_LRD_IDX, I_PC_STEP, I_WR_DATA, I_LWR_DATA, I_PC_DATA} = 0;
		{I_VTB_DATA, a, b, I_ALU_BYTE, I_UPD_C, I_UPD_ZS, I_UPD_O, failures, total_checks} = 0;
		I_SYS_RST = 1'b1;
		i = $urandom(2);
		repeat (5) @(posedge I_CORE_CLK);
		I_SYS_RST <= 1'b0;
		for (i = 0; i < 16; i = i + 1) begin
			if (i < 10) ex[i] = 16'h0000;
			rd(i[3:0], 16'h0000);
		end
		$display("reset done");
		for (n = 0; n < 60; n = n + 1) begin
			i = $urandom % 10;
			d = $urandom;
			if (i > 3 || d[17:16] == 2'b00) d[17:16] = 2'b11;
			wr(i[3:0], d[17:0]);
			ex[i] = {d[17] ? d[15:8] : ex[i][15:8], d[16] ? d[7:0] : ex[i][7:0]};
			rd(i[3:0], ex[i]);
		end
		chk(O_SB, ex[7]);
		chk(O_FB, ex[6]);
		chk(O_SP, ex[9]);
		rd(4'ha, ex[9]);
		wr(4'hb, 18'h3fffd);
		rd(4'hb, 16'h07fd);
		rd(4'ha, ex[8]);
		chk(O_SP, ex[8]);
		chk(O_BANK, 1'b1);
		rd(4'h0, 16'h0000);
		wr(4'h6, 18'h3a5c3);
		rd(4'h6, 16'ha5c3);
		chk(O_FB, 16'ha5c3);
		wr(4'hb, 18'h30000);
		rd(4'h0, ex[0]);
		rd(4'h5, ex[5]);
		rd(4'h6, ex[6]);
		$display("flags done");
		for (n = 0; n < 3; n = n + 1) begin
			d = $urandom;
			@(posedge I_CORE_CLK);
			{I_LWR_IDX, I_LWR_DATA, I_LWR_EN} <= {n[1:0], d, 1'b1};
			@(posedge I_CORE_CLK);
			{I_LRD_IDX, I_LRD_EN, I_LWR_EN} <= {n[1:0], 2'b10};
			@(posedge I_CORE_CLK);
			I_LRD_EN <= 1'b0;
			#1 chk(O_LRD_DATA, d);
			rd(n == 2 ? 4'h5 : n[3:0] + 4'h2, d[31:16]);
		end
		d = $urandom;
		@(posedge I_CORE_CLK);
		{I_PC_LOAD, I_PC_DATA, I_VTB_LOAD, I_VTB_DATA} <= {1'b1, d[19:0], 1'b1, d[31:12]};
		@(posedge I_CORE_CLK);
		{I_PC_LOAD, I_VTB_LOAD, I_PC_INC, I_PC_STEP} <= 6'h0f;
		@(posedge I_CORE_CLK);
		I_PC_INC <= 1'b0;
		@(posedge I_CORE_CLK);
		#1 chk(O_PC, {12'h000, d[19:0] + 20'h00007});
		chk(O_VTB, d[31:12]);
		wr(4'he, 18'h3ffff);
		rd(4'he, d[15:0] + 16'h0007);
		d = $urandom;
		wr(4'hc, {2'b11, d[15:0]});
		wr(4'hd, {2'b01, d[31:16]});
		rd(4'hc, d[15:0]);
		rd(4'hd, {12'h000, d[19:16]});
		chk(O_VTB, d[19:0]);
		$display("long and pc done");
		fx = 11'h000;
		for (n = 0; n < 40; n = n + 1) begin
			d = n < 2 ? (n ? 32'hffff0001 : 32'h7fff0001) : $urandom;
			i = n < 2 ? 7 : $urandom;
			@(posedge I_CORE_CLK);
			{go, a, b, I_ALU_BYTE, I_UPD_O, I_UPD_ZS, I_UPD_C} <= {1'b1, d, i[3:0]};
			@(posedge I_CORE_CLK);
			go <= 1'b0;
			repeat (2) @(posedge I_CORE_CLK);
			f = flags(a, b, I_ALU_BYTE);
			if (I_UPD_C) fx[0] = f[0];
			if (I_UPD_ZS) fx[3:2] = f[2:1];
			if (I_UPD_O) fx[5] = f[3];
			#1 chk(O_FLG, fx);
		end
		$display("alu done");
		finish_test;
	end
endmodule
